//--- design/two_wire_slave.sv
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module two_wire_slave
    import two_wire_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        SCL_IN,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    state_t st_r;
    state_t st_nxt;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] ctrl_byte(input regs_t rg, input phase_t ph);
        logic [7:0] v;
        v = RESET_BYTE;
        v[CTL_ENABLE_BIT] = rg.two_wire_enable;
        v[CTL_FLAG_BIT]   = rg.byte_event_flag;
        v[CTL_GCHIT_BIT]  = rg.general_call_hit_flag;
        v[CTL_ACKEN_BIT]  = rg.acknowledge_enable;
        v[CTL_PHASE_LSB +: 3] = ph;
        return v;
    endfunction : ctrl_byte

    function automatic logic [31:0] read_word(input logic [9:0] idx, input state_t s);
        logic [31:0] w;
        w = '0;
        case (idx)
            IDX_SERIAL_CONTROL: w[7:0] = ctrl_byte(s.regs, s.eng.phase);
            IDX_SLAVE_ADDRESS:  w[7:0] = {s.regs.own_slave_address,
                                          s.regs.general_call_enable};
            IDX_BYTE_BUFFER:    w[7:0] = s.regs.byte_buffer;
            default:            w = '0;
        endcase
        return w;
    endfunction : read_word

    // Register index carried in the word-aligned byte address
    function automatic logic [9:0] reg_index(input logic [31:0] addr);
        logic [9:0] idx;
        idx = addr[IDX_MSB:IDX_LSB];
        return idx;
    endfunction : reg_index

    // NONSEQ and SEQ open a transfer; IDLE and BUSY are ignored
    function automatic logic bus_request(input logic       sel,
                                         input logic       rdy,
                                         input logic [1:0] trans);
        logic req;
        req = sel && rdy && (trans == HTRANS_NONSEQ || trans == HTRANS_SEQ);
        return req;
    endfunction : bus_request

    // An address is answered only while software accepts transfers
    function automatic logic frame_accepted(input logic own,
                                            input logic gc,
                                            input logic acken);
        logic acc;
        acc = (own || gc) && acken;
        return acc;
    endfunction : frame_accepted

    // Data line moving while the clock line stays high marks start or stop
    function automatic logic line_event(input logic scl_c,
                                        input logic scl_p,
                                        input logic sda_c,
                                        input logic sda_p,
                                        input logic fall);
        logic hit;
        hit = scl_c && scl_p && (fall ? (sda_p && !sda_c) : (!sda_p && sda_c));
        return hit;
    endfunction : line_event

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic       scl_now;
        logic       sda_now;
        logic       scl_rise;
        logic       scl_fall;
        logic       start_seen;
        logic       stop_seen;
        logic       own_hit;
        logic       gc_hit;
        logic [7:0] frame;
        scl_now    = 1'b0;
        sda_now    = 1'b0;
        scl_rise   = 1'b0;
        scl_fall   = 1'b0;
        start_seen = 1'b0;
        stop_seen  = 1'b0;
        own_hit    = 1'b0;
        gc_hit     = 1'b0;
        frame      = RESET_BYTE;
        st_nxt     = st_r;

        // ------------------------------------------------------------
        // Line synchronisers and events
        // ------------------------------------------------------------
        // two-flop synchronisers, edges taken after the second flop
        st_nxt.line.scl_sync = {st_r.line.scl_sync[0], SCL_IN};
        st_nxt.line.sda_sync = {st_r.line.sda_sync[0], SDA_IN};
        st_nxt.line.scl_prev = st_r.line.scl_sync[1];
        st_nxt.line.sda_prev = st_r.line.sda_sync[1];
        scl_now    = st_r.line.scl_sync[1];
        sda_now    = st_r.line.sda_sync[1];
        scl_rise   = scl_now & ~st_r.line.scl_prev;
        scl_fall   = ~scl_now & st_r.line.scl_prev;
        // start and stop while SCL high
        start_seen = line_event(scl_now, st_r.line.scl_prev,
                                sda_now, st_r.line.sda_prev, 1'b1);
        stop_seen  = line_event(scl_now, st_r.line.scl_prev,
                                sda_now, st_r.line.sda_prev, 1'b0);

        // ------------------------------------------------------------
        // AHB-Lite slave, zero wait states
        // ------------------------------------------------------------
        st_nxt.bus.ready = 1'b1;
        st_nxt.bus.resp  = HRESP_OKAY;
        st_nxt.bus.wr_pending = 1'b0;
        if (st_r.bus.wr_pending)
        begin
            case (st_r.bus.wr_index)
                IDX_SERIAL_CONTROL:
                begin
                    st_nxt.regs.two_wire_enable    = HWDATA[CTL_ENABLE_BIT];
                    st_nxt.regs.acknowledge_enable = HWDATA[CTL_ACKEN_BIT];
                    // only a software write clears the flag
                    // Writing zero clears; writing one leaves the flag alone
                    if (!HWDATA[CTL_FLAG_BIT])
                        st_nxt.regs.byte_event_flag = 1'b0;
                end
                IDX_SLAVE_ADDRESS:
                begin
                    st_nxt.regs.own_slave_address   = HWDATA[ADR_OWN_LSB +: 7];
                    st_nxt.regs.general_call_enable = HWDATA[ADR_GCE_BIT];
                end
                // buffer written by software feeds the next shift-out
                IDX_BYTE_BUFFER: st_nxt.regs.byte_buffer = HWDATA[7:0];
                default: st_nxt.regs = st_nxt.regs;
            endcase
        end
        if (bus_request(HSEL, HREADY, HTRANS))
        begin
            st_nxt.bus.wr_pending = HWRITE;
            st_nxt.bus.wr_index   = reg_index(HADDR);
            if (!HWRITE)
                st_nxt.bus.rdata = read_word(reg_index(HADDR), st_r);
        end

        // ------------------------------------------------------------
        // Serial engine
        // ------------------------------------------------------------
        frame   = st_r.eng.shift;
        own_hit = frame[7:1] == st_r.regs.own_slave_address;
        // general call only when enabled, write direction only
        gc_hit  = st_r.regs.general_call_enable && frame[7:1] == GEN_CALL_ADDR && !frame[0];

        // the engine only reacts to the master's SCL, never drives it
        if (!st_r.regs.two_wire_enable)
        begin
            st_nxt.eng.phase  = PH_IDLE;
            st_nxt.eng.sda_oe = 1'b0;
            st_nxt.eng.count  = CNT_ZERO;
        end
        else if (start_seen)
        begin
            // restart while addressed raises the event flag
            if (st_r.eng.phase != PH_IDLE && st_r.eng.phase != PH_ADDRESS)
                st_nxt.regs.byte_event_flag = 1'b1;
            // start moves to the address phase
            // restart from receive returns to 001 as well
            st_nxt.eng.phase  = PH_ADDRESS;
            st_nxt.eng.count  = CNT_ZERO;
            st_nxt.eng.sda_oe = 1'b0;
        end
        else if (stop_seen)
        begin
            // stop seen while taking part in a transfer
            if (st_r.eng.phase != PH_IDLE)
                st_nxt.regs.byte_event_flag = 1'b1;
            st_nxt.eng.phase  = PH_IDLE;
            st_nxt.eng.sda_oe = 1'b0;
            // hit flag drops on its own at the end of the transfer
            st_nxt.regs.general_call_hit_flag = 1'b0;
        end
        else if (scl_rise && st_r.eng.phase != PH_IDLE)
        begin
            if (st_r.eng.count != BITS_PER_BYTE)
            begin
                // data sampled on the rising clock
                st_nxt.eng.shift = {st_r.eng.shift[6:0], sda_now};
                st_nxt.eng.count = st_r.eng.count + CNT_ONE;
            end
            else
            begin
                st_nxt.eng.count = CNT_ZERO;
                case (st_r.eng.phase)
                    PH_ADDRESS:
                    begin
                        if (frame_accepted(own_hit, gc_hit, st_r.regs.acknowledge_enable))
                        begin
                            st_nxt.regs.byte_event_flag = 1'b1;
                            // hit flag set on general-call match, unless the own address matches as well
                            st_nxt.regs.general_call_hit_flag = gc_hit & ~own_hit;
                            // direction bit chooses the next phase
                            if (frame[0])
                            begin
                                st_nxt.eng.phase = PH_SEND;
                                st_nxt.eng.shift = st_r.regs.byte_buffer;
                            end
                            else
                                st_nxt.eng.phase = PH_RECEIVE;
                        end
                        else
                            st_nxt.eng.phase = PH_IDLE;
                    end
                    PH_RECEIVE:
                    begin
                        // Received byte wins over a software write in the same cycle
                        st_nxt.regs.byte_buffer = frame;
                        st_nxt.regs.byte_event_flag = 1'b1;
                        if (!st_r.regs.acknowledge_enable)
                            st_nxt.eng.phase = PH_IDLE;
                    end
                    PH_SEND:
                    begin
                        st_nxt.regs.byte_event_flag = 1'b1;
                        if (sda_now)
                            st_nxt.eng.phase = PH_NACKED;
                        else if (!st_r.regs.acknowledge_enable)
                            st_nxt.eng.phase = PH_ABORTED;
                        else
                            st_nxt.eng.shift = st_r.regs.byte_buffer;
                    end
                    default: st_nxt.eng.phase = st_r.eng.phase;
                endcase
            end
        end
        else if (scl_fall)
        begin
            // own SDA is taken only after SCL falls; clearing the enable releases it at once
            st_nxt.eng.sda_oe = 1'b0;
            if (st_r.eng.count == BITS_PER_BYTE)
            begin
                case (st_r.eng.phase)
                    PH_ADDRESS: st_nxt.eng.sda_oe = frame_accepted(own_hit, gc_hit,
                                    st_r.regs.acknowledge_enable);
                    PH_RECEIVE: st_nxt.eng.sda_oe = st_r.regs.acknowledge_enable;
                    default:    st_nxt.eng.sda_oe = 1'b0;
                endcase
            end
            else if (st_r.eng.phase == PH_SEND)
                // drive data bits, ninth clock left released
                st_nxt.eng.sda_oe = ~st_r.eng.shift[7];
        end

        st_nxt.eng.sda_low = 1'b0;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            // Lines reset to their idle high level so no false edge follows reset
            st_r <= '{
                line: '{
                    scl_sync: 2'h3,
                    sda_sync: 2'h3,
                    scl_prev: 1'b1,
                    sda_prev: 1'b1
                },
                bus:  '{
                    wr_pending: 1'b0,
                    wr_index:   10'h000,
                    rdata:      32'h0000_0000,
                    ready:      1'b1,
                    resp:       HRESP_OKAY
                },
                regs: '{
                    own_slave_address:     7'h00,
                    general_call_enable:   1'b0,
                    two_wire_enable:       1'b0,
                    byte_event_flag:       1'b0,
                    general_call_hit_flag: 1'b0,
                    acknowledge_enable:    1'b0,
                    byte_buffer:           RESET_BYTE
                },
                eng:  '{
                    phase:   PH_IDLE,
                    shift:   RESET_BYTE,
                    count:   CNT_ZERO,
                    sda_oe:  1'b0,
                    sda_low: 1'b0
                }
            };
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from flops
    // ------------------------------------------------------------
    assign HRDATA    = st_r.bus.rdata;
    assign HREADYOUT = st_r.bus.ready;
    assign HRESP     = st_r.bus.resp;
    assign SDA_OUT   = st_r.eng.sda_low;
    assign SDA_OE    = st_r.eng.sda_oe;

endmodule : two_wire_slave

//--- design/two_wire_pkg.sv
package two_wire_pkg;

    // ------------------------------------------------------------
    // Register map (printed offsets are indices, byte address = 4x)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_SERIAL_CONTROL = 10'h09d;
    localparam logic [9:0] IDX_SLAVE_ADDRESS  = 10'h09e;
    localparam logic [9:0] IDX_BYTE_BUFFER    = 10'h09f;
    localparam int         IDX_LSB            = 2;
    localparam int         IDX_MSB            = 11;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_FLAG_BIT   = 6;
    localparam int CTL_GCHIT_BIT  = 4;
    localparam int CTL_ACKEN_BIT  = 3;
    localparam int CTL_PHASE_LSB  = 0;

    // Address register fields
    localparam int ADR_OWN_LSB = 1;
    localparam int ADR_GCE_BIT = 0;

    // ------------------------------------------------------------
    // Reset values and constants
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE    = 8'h00;
    localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] CNT_ZERO      = 4'h0;
    localparam logic [3:0] CNT_ONE       = 4'h1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic       HRESP_OKAY    = 1'b0;

    // ------------------------------------------------------------
    // Phase codes as seen by software
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE    = 3'b000,
        PH_ADDRESS = 3'b001,
        PH_RECEIVE = 3'b010,
        PH_SEND    = 3'b011,
        PH_NACKED  = 3'b100,
        PH_ABORTED = 3'b101
    } phase_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic       scl_prev;
        logic       sda_prev;
    } line_sync_t;

    typedef struct packed {
        logic       wr_pending;
        logic [9:0] wr_index;
        logic [31:0] rdata;
        logic       ready;
        logic       resp;
    } bus_state_t;

    typedef struct packed {
        logic [6:0] own_slave_address;
        logic       general_call_enable;
        logic       two_wire_enable;
        logic       byte_event_flag;
        logic       general_call_hit_flag;
        logic       acknowledge_enable;
        logic [7:0] byte_buffer;
    } regs_t;

    typedef struct packed {
        phase_t     phase;
        logic [7:0] shift;
        logic [3:0] count;
        logic       sda_oe;
        logic       sda_low;
    } engine_t;

    typedef struct packed {
        line_sync_t line;
        bus_state_t bus;
        regs_t      regs;
        engine_t    eng;
    } state_t;

endpackage : two_wire_pkg

//--- bench/two_wire_master_model.sv
`timescale 1ns/1ps
module two_wire_master_model (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda_line
);
    // ----------------------------------------
    // Master state
    // ----------------------------------------
    logic mid;

    initial
    begin
        scl     = 1'b1;
        sda_low = 1'b0;
        mid     = 1'b0;
    end

    // one clock period
    // Data moves mid low half; sampled late high, clear of the slave's update
    task automatic bit_x(input logic b, output logic r);
        scl = 1'b0;
        #200 sda_low = !b;
        #200 scl = 1'b1;
        #390 r = sda_line;
        #10;
    endtask : bit_x

    // SCL stands high between frames; offset keeps edges off the system clock
    task automatic send_start();
        #13;
        if (mid)
        begin
            scl = 1'b0;
            #200 sda_low = 1'b0;
            #200 scl = 1'b1;
            #400;
        end
        sda_low = 1'b1;
        #400 mid = 1'b1;
    endtask : send_start

    task automatic send_stop();
        #13 scl = 1'b0;
        #200 sda_low = 1'b1;
        #200 scl = 1'b1;
        #400 sda_low = 1'b0;
        #400 mid = 1'b0;
    endtask : send_stop

    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack_out);
        #13;
        for (int i = 7; i >= 0; i--)
            bit_x(tx[i], rx[i]);
        bit_x(ack_in, ack_out);
    endtask : xfer
endmodule : two_wire_master_model

//--- bench/two_wire_slave_properties.sv
`timescale 1ns/1ps
module two_wire_slave_properties (
    input wire logic        CLK,
    input wire logic        RESET_N,
    input wire logic        HSEL,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic        SCL_IN,
    input wire logic        SDA_IN,
    input wire logic        SDA_OUT,
    input wire logic        SDA_OE
);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    property p_open_drain; SDA_OUT == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("sda value not low");
    // Slack of 2 and 6 cycles covers the two-flop synchroniser delay
    property p_oe_moves_low; $changed(SDA_OE) |-> !$past(SCL_IN, 2) && $past(SCL_IN, 6);
    endproperty
    a_oe_moves_low: assert property (p_oe_moves_low)
        else $error("sda moved off low scl");
    property p_quiet_high;
        SCL_IN && $past(SCL_IN) && $past(SCL_IN, 2) && $past(SCL_IN, 3) |-> $stable(SDA_OE);
    endproperty
    a_quiet_high: assert property (p_quiet_high) else $error("sda moved with scl high");
    property p_bit_holds; $rose(SDA_OE) |-> SDA_OE [*6]; endproperty
    a_bit_holds: assert property (p_bit_holds) else $error("driven bit too short");
    property p_start_quiet; SCL_IN && $fell(SDA_IN) && !SDA_OE |=> !SDA_OE [*3]; endproperty
    a_start_quiet: assert property (p_start_quiet)
        else $error("drive right after start");
    property p_ready; HREADYOUT == 1'b1; endproperty
    a_ready: assert property (p_ready) else $error("wait state inserted");
    property p_okay; HRESP == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("error response");
    property p_rdata_hold;
        !($past(HSEL) && $past(HREADY) && $past(HTRANS[1]) && !$past(HWRITE))
            |-> $stable(HRDATA) && HRDATA[31:8] == 24'h0;
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

    c_drive: cover property ($rose(SDA_OE));
    c_start: cover property (SCL_IN && $fell(SDA_IN));
    c_read: cover property (HSEL && HTRANS[1] && !HWRITE);
endmodule : two_wire_slave_properties

bind two_wire_slave two_wire_slave_properties prop_u (
    .CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE)
);

//--- bench/two_wire_slave_tb_top.sv
`timescale 1ns/1ps
module two_wire_slave_tb_top
    import two_wire_pkg::*;
;
    localparam logic [9:0] CTL = IDX_SERIAL_CONTROL;
    localparam logic [9:0] ADR = IDX_SLAVE_ADDRESS;
    localparam logic [9:0] BUF = IDX_BYTE_BUFFER;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk, reset_n, hsel, hwrite, hreadyout, hresp, scl, m_low, sda_out, sda_oe, ack;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  rx;
    int          n_fail, checked;
    wire         sda_line;

    // Pull-up wins unless someone pulls low
    assign sda_line = !((sda_oe && !sda_out) || m_low);
    always #50 clk = ~clk;

    two_wire_slave dut_u (
        .CLK(clk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .SCL_IN(scl),
        .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE(sda_oe)
    );
    two_wire_master_model mdl_u (.scl(scl), .sda_low(m_low), .sda_line(sda_line));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] wd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= {20'h0, idx, 2'b00};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic expect_reg(input string what, input logic [9:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(what, exp, rd[7:0]);
    endtask : expect_reg

    task automatic expect_phase(input logic [2:0] exp);
        bus(1'b0, CTL, 8'h00);
        check("phase", {5'h0, exp}, {5'h0, rd[2:0]});
    endtask : expect_phase

    task automatic frame(input logic [7:0] b, input logic exp_ack);
        mdl_u.xfer(b, 1'b1, rx, ack);
        check("acknowledge", {7'h0, exp_ack}, {7'h0, ack});
    endtask : frame

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        expect_reg("control", CTL, 8'h00);
        expect_reg("address", ADR, RESET_BYTE);
        expect_reg("buffer", BUF, RESET_BYTE);
        bus(1'b1, 10'h3ff, 8'h5a);
        expect_reg("unmapped", 10'h3ff, 8'h00);
        bus(1'b1, CTL, 8'hff);
        expect_reg("control", CTL, 8'h88);
        bus(1'b1, ADR, 8'hb4);
        expect_reg("address", ADR, 8'hb4);
    endtask : t_regs

    task automatic t_receive();
        mdl_u.send_start();
        expect_reg("control", CTL, 8'h89);
        frame(8'hb4, 1'b0);
        expect_reg("control", CTL, 8'hca);
        bus(1'b1, CTL, 8'h88);
        frame(8'hc3, 1'b0);
        expect_reg("buffer", BUF, 8'hc3);
        frame(8'h3c, 1'b0);
        expect_reg("control", CTL, 8'hca);
        expect_reg("buffer", BUF, 8'h3c);
        bus(1'b1, CTL, 8'h88);
        mdl_u.send_start();
        expect_reg("control", CTL, 8'hc9);
        frame(8'hb4, 1'b0);
        bus(1'b1, CTL, 8'h88);
        mdl_u.send_stop();
        expect_reg("control", CTL, 8'hc8);
    endtask : t_receive

    task automatic t_refuse_rx();
        mdl_u.send_start();
        frame(8'hb4, 1'b0);
        bus(1'b1, CTL, 8'h80);
        frame(8'h77, 1'b1);
        expect_phase(3'b000);
        mdl_u.send_stop();
        bus(1'b1, CTL, 8'h88);
    endtask : t_refuse_rx

    task automatic t_transmit();
        bus(1'b1, BUF, 8'ha5);
        mdl_u.send_start();
        frame(8'hb5, 1'b0);
        expect_reg("control", CTL, 8'hcb);
        bus(1'b1, CTL, 8'h88);
        fork
            mdl_u.xfer(8'hff, 1'b0, rx, ack);
            bus(1'b1, BUF, 8'h3c);
        join
        check("sent byte", 8'ha5, rx);
        expect_reg("control", CTL, 8'hcb);
        mdl_u.xfer(8'hff, 1'b1, rx, ack);
        check("sent byte", 8'h3c, rx);
        expect_phase(3'b100);
        mdl_u.send_stop();
        expect_phase(3'b000);
    endtask : t_transmit

    task automatic t_abort_tx();
        mdl_u.send_start();
        frame(8'hb5, 1'b0);
        bus(1'b1, CTL, 8'h80);
        mdl_u.xfer(8'hff, 1'b0, rx, ack);
        check("sent byte", 8'h3c, rx);
        expect_phase(3'b101);
        check("release", 8'h00, {7'h0, sda_oe});
        mdl_u.send_stop();
        expect_phase(3'b000);
    endtask : t_abort_tx

    task automatic t_gcall();
        bus(1'b1, ADR, 8'hb5);
        bus(1'b1, CTL, 8'h88);
        mdl_u.send_start();
        frame(8'h00, 1'b0);
        expect_reg("control", CTL, 8'hda);
        mdl_u.send_stop();
        expect_reg("control", CTL, 8'hc8);
        bus(1'b1, ADR, 8'hb4);
        mdl_u.send_start();
        frame(8'h00, 1'b1);
        expect_phase(3'b000);
        mdl_u.send_start();
        frame(8'h22, 1'b1);
        expect_phase(3'b000);
        mdl_u.send_stop();
        bus(1'b1, CTL, 8'h08);
        mdl_u.send_start();
        expect_phase(3'b000);
        frame(8'hb4, 1'b1);
        mdl_u.send_stop();
        bus(1'b1, CTL, 8'h88);
        expect_phase(3'b000);
    endtask : t_gcall

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        clk     = 1'b0;
        reset_n = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h0;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h0;
        n_fail  = 0;
        checked = 0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_receive();
        t_refuse_rx();
        t_transmit();
        t_abort_tx();
        t_gcall();
        print_verdict();
    end

    // Whole run needs well under 0.5 ms
    initial
    begin
        #2000000;
        n_fail++;
        print_verdict();
    end
endmodule : two_wire_slave_tb_top
